// ---- inc/asm_access_defines.svh ----
// constants for the holding register request handler
`ifndef ASM_ACCESS_DEFINES_SVH
`define ASM_ACCESS_DEFINES_SVH
// function codes
`define FC_RD_HOLD 8'h03
`define FC_WR_SINGLE 8'h06
`define FC_WR_MULTI 8'h10
`define FC_RD_WR_MULTI 8'h17
// exception codes
`define EXC_NONE 8'h00
`define EXC_BAD_FC 8'h01
`define EXC_BAD_ADDR 8'h02
`define EXC_BAD_QTY 8'h03
// sizes
`define NUM_REGS 512
`define MAX_QTY 45
`define IDX_W 9
`define IMG_BYTES 64
// zero-based protocol offsets of assembly starts (4:1500 and 4:1600)
`define IN_ASM_OFF 16'h05db
`define OUT_ASM_OFF 16'h063f
`define IN_ASM_LEN 21
`define OUT_ASM_LEN 16
// one-based module addresses of input assembly members
`define IN_M0 10'h074
`define IN_M1 10'h0c4
`define IN_M2 10'h06a
`define IN_M3 10'h06b
`define IN_M4 10'h0ba
`define IN_M5 10'h0bb
`define IN_FILL 10'h078
// one-based module address of first output assembly member
`define OUT_MAP 10'h105
// neighbour hand-off register (one-based) and the value that starts conveying
`define HAND_ADDR 10'h0fa
`define HAND_VAL 16'h0001
`endif

// ---- inc/asm_access_pkg.sv ----
// types for the holding register request handler
package asm_access_pkg;
  typedef struct packed {
    logic [7:0] fc;
    logic [15:0] rd_off;
    logic [7:0] rd_qty;
    logic [15:0] wr_off;
    logic [7:0] wr_qty;
  } req_s;
  typedef struct packed {
    logic valid;
    logic last;
    logic [15:0] data;
  } rsp_s;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WR = 2'b01,
    S_RD = 2'b10,
    S_DONE = 2'b11
  } state_e;
endpackage : asm_access_pkg

// ---- logic/asm_access.sv ----
// holding register table with assembly gathering and image ports
`timescale 1ns/1ps
`include "asm_access_defines.svh"
// Overview of operation
// - each table location holds a 16-bit value, readable and writable
// - a fixed table of 512 physical register locations
// - function 3 reads up to 45 holding registers
// - function 6 writes one 16-bit value to one register
// - function 16 writes up to 45 registers
// - function 23 writes then reads, each part up to 45 registers
// - assembly addresses are virtual; members are gathered into one image
// - assembly access not starting at its first address gets an error
// - input assembly starts at 4:1500; a start at 4:1504 is refused
// - addresses are one-based; protocol offset is address minus one
// - input assembly gathers 21 scattered registers into consecutive words
// - every access path uses the same register storage
// - a 64-byte input image and a 64-byte output image
// - image items sit at fixed byte offsets from the image base
// - writing the hand-off value to the hand-off register starts conveying
// - output image carries controller writes, input image device values
// - neighbour traffic uses the same register write requests
// - image word takes two bytes, high byte even, low byte odd
module asm_access
  import asm_access_pkg::*;
#(
  parameter int NREG = `NUM_REGS,
  parameter int MAXQ = `MAX_QTY
) (
  input wire logic core_clk_i, // 20 MHz clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic req_valid_i, // request strobe
  input wire req_s req_i, // request fields
  input wire logic wr_valid_i, // write word strobe
  input wire logic [15:0] wr_data_i, // write word
  input wire logic img_rd_i, // input image byte read
  input wire logic [5:0] img_rd_addr_i, // input image byte offset
  input wire logic img_wr_i, // output image byte write
  input wire logic [5:0] img_wr_addr_i, // output image byte offset
  input wire logic [7:0] img_wr_data_i, // output image byte
  output logic busy_o, // request in progress
  output logic wr_ready_o, // write words accepted
  output rsp_s rsp_o, // read word answer
  output logic done_o, // request finished pulse
  output logic [7:0] exc_o, // exception code of last request
  output logic img_rd_valid_o, // input image byte valid
  output logic [7:0] img_rd_data_o, // input image byte
  output logic convey_start_o // hand-off seen pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (NREG > (1 << `IDX_W) || NREG < 1) begin : g_bad_nreg
    $error("NREG out of range");
  end
  if (MAXQ > 255 || MAXQ < 1) begin : g_bad_maxq
    $error("MAXQ out of range");
  end
  // the whole input assembly must be readable in one request
  if (MAXQ < `IN_ASM_LEN) begin : g_short_maxq
    $error("MAXQ below the input assembly length");
  end
  // both assembly images must fit the fixed image size
  if (2 * `IN_ASM_LEN > `IMG_BYTES) begin : g_bad_in_img
    $error("input assembly larger than its image");
  end
  if (2 * `OUT_ASM_LEN > `IMG_BYTES) begin : g_bad_out_img
    $error("output assembly larger than its image");
  end
  // physical span must end below the virtual assembly offsets
  if (NREG > `IN_ASM_OFF) begin : g_bad_asm_off
    $error("NREG overlaps the assembly offsets");
  end

  ////////////////////////////////////////////////////////////////////////////
  // address mapping

  // member of the input assembly at word k, as a table index
  function automatic logic [`IDX_W-1:0] in_member(input logic [15:0] k);
    logic [9:0] a;
    case (k)
      16'h0000: a = `IN_M0;
      16'h0001: a = `IN_M1;
      16'h0002: a = `IN_M2;
      16'h0003: a = `IN_M3;
      16'h0004: a = `IN_M4;
      16'h0005: a = `IN_M5;
      default: a = 10'(`IN_FILL + k[9:0]);
    endcase
    in_member = `IDX_W'(a - 10'h001);
  endfunction : in_member

  // member of the output assembly at word k
  function automatic logic [`IDX_W-1:0] out_member(input logic [15:0] k);
    logic [9:0] a;
    a = 10'(`OUT_MAP + k[9:0]);
    out_member = `IDX_W'(a - 10'h001);
  endfunction : out_member

  // protocol offset to table index; assemblies resolve to members
  function automatic logic [`IDX_W-1:0] map_off(input logic [15:0] off);
    logic [`IDX_W-1:0] r;
    r = off[`IDX_W-1:0];
    if (off >= `OUT_ASM_OFF) begin
      r = out_member(16'(off - `OUT_ASM_OFF));
    end else if (off >= `IN_ASM_OFF) begin
      r = in_member(16'(off - `IN_ASM_OFF));
    end
    map_off = r;
  endfunction : map_off

  // range check: physical span, or an assembly from its first word only
  function automatic logic span_ok(input logic [15:0] off,
                                   input logic [7:0] qty);
    logic [16:0] endw;
    logic ok;
    endw = 17'(off) + 17'(qty);
    ok = 1'b0;
    if (endw <= 17'(NREG)) begin
      ok = 1'b1;
    end else if (off == `IN_ASM_OFF) begin
      ok = (qty <= 8'(`IN_ASM_LEN));
    end else if (off == `OUT_ASM_OFF) begin
      ok = (qty <= 8'(`OUT_ASM_LEN));
    end
    span_ok = ok;
  endfunction : span_ok

  ////////////////////////////////////////////////////////////////////////////
  // storage shared by every access path
  logic [15:0] mem [NREG];

  ////////////////////////////////////////////////////////////////////////////
  // request decode
  wire logic is_rd = (req_i.fc == `FC_RD_HOLD);
  wire logic is_w1 = (req_i.fc == `FC_WR_SINGLE);
  wire logic is_wm = (req_i.fc == `FC_WR_MULTI);
  wire logic is_rw = (req_i.fc == `FC_RD_WR_MULTI);
  wire logic fc_ok = is_rd | is_w1 | is_wm | is_rw;
  wire logic rd_q_ok = (req_i.rd_qty != 8'h00) &&
                       (req_i.rd_qty <= 8'(MAXQ));
  wire logic wr_q_ok = (req_i.wr_qty != 8'h00) &&
                       (req_i.wr_qty <= 8'(MAXQ));
  wire logic q_ok = is_w1 | ((is_rd | is_rw) ? rd_q_ok : 1'b1) &
                    ((is_wm | is_rw) ? wr_q_ok : 1'b1);
  wire logic rd_a_ok = span_ok(req_i.rd_off, req_i.rd_qty);
  // a single-register write checks one word whatever its quantity field
  wire logic wr_a_ok = span_ok(req_i.wr_off, is_w1 ? 8'h01 : req_i.wr_qty);
  wire logic a_ok = ((is_rd | is_rw) ? rd_a_ok : 1'b1) &
                    ((is_w1 | is_wm | is_rw) ? wr_a_ok : 1'b1);
  // exception priority: function, then quantity, then address
  wire logic [7:0] req_exc = !fc_ok ? `EXC_BAD_FC :
                             !q_ok ? `EXC_BAD_QTY :
                             !a_ok ? `EXC_BAD_ADDR : `EXC_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state
  state_e state_ff, nxt_state;
  req_s req_ff;
  logic [15:0] cur_ff, nxt_cur;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [7:0] exc_ff;
  logic busy_ff, wr_ready_ff, done_ff, conv_ff, img_v_ff;
  rsp_s rsp_ff;
  logic [7:0] img_d_ff;

  wire logic take_req = (state_ff == S_IDLE) && req_valid_i;
  wire logic take_wr = (state_ff == S_WR) && wr_valid_i;
  wire logic [`IDX_W-1:0] wr_idx = map_off(cur_ff);
  wire logic [`IDX_W-1:0] rd_idx = map_off(cur_ff);
  wire logic is_hand = (wr_idx == `IDX_W'(`HAND_ADDR - 10'h001)) &&
                       (wr_data_i == `HAND_VAL);

  // next state and counters
  always_comb begin
    nxt_state = state_ff;
    nxt_cur = cur_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      S_IDLE: begin
        if (req_valid_i) begin
          if (req_exc != `EXC_NONE) begin
            nxt_state = S_DONE;
          end else if (is_rd) begin
            nxt_state = S_RD;
            nxt_cur = req_i.rd_off;
            nxt_cnt = req_i.rd_qty;
          end else begin
            nxt_state = S_WR;
            nxt_cur = req_i.wr_off;
            nxt_cnt = is_w1 ? 8'h01 : req_i.wr_qty;
          end
        end
      end
      S_WR: begin
        if (wr_valid_i) begin
          nxt_cur = 16'(cur_ff + 16'h0001);
          nxt_cnt = 8'(cnt_ff - 8'h01);
          if (cnt_ff == 8'h01) begin
            if (req_ff.fc == `FC_RD_WR_MULTI) begin
              nxt_state = S_RD;
              nxt_cur = req_ff.rd_off;
              nxt_cnt = req_ff.rd_qty;
            end else begin
              nxt_state = S_DONE;
            end
          end
        end
      end
      S_RD: begin
        nxt_cur = 16'(cur_ff + 16'h0001);
        nxt_cnt = 8'(cnt_ff - 8'h01);
        if (cnt_ff == 8'h01) begin
          nxt_state = S_DONE;
        end
      end
      S_DONE: begin
        nxt_state = S_IDLE;
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= S_IDLE;
      cur_ff <= 16'h0000;
      cnt_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      cur_ff <= nxt_cur;
      cnt_ff <= nxt_cnt;
    end
  end

  // request fields kept for the later phases of a transfer
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_ff <= '0;
    end else if (take_req) begin
      req_ff <= req_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // image decode: byte offset to word and half
  wire logic [4:0] ir_word = img_rd_addr_i[5:1];
  wire logic [4:0] iw_word = img_wr_addr_i[5:1];
  wire logic [`IDX_W-1:0] ir_idx = in_member(16'(ir_word));
  wire logic [`IDX_W-1:0] iw_idx = out_member(16'(iw_word));
  // bytes past the last assembly member read as zero
  wire logic ir_hit = (ir_word < 5'(`IN_ASM_LEN));
  wire logic iw_hit = img_wr_i &&
                      ({1'b0, iw_word} < 6'(`OUT_ASM_LEN));
  wire logic [15:0] ir_word_val = ir_hit ? mem[ir_idx] : 16'h0000;
  wire logic [7:0] ir_byte = img_rd_addr_i[0] ? ir_word_val[7:0] :
                             ir_word_val[15:8];

  ////////////////////////////////////////////////////////////////////////////
  // storage write port: request words first, image bytes otherwise
  // an image byte that meets a request word in one cycle is dropped
  always_ff @(posedge core_clk_i) begin
    if (take_wr) begin
      mem[wr_idx] <= wr_data_i;
    end else if (iw_hit) begin
      if (img_wr_addr_i[0]) begin
        mem[iw_idx][7:0] <= img_wr_data_i;
      end else begin
        mem[iw_idx][15:8] <= img_wr_data_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer registers
  wire logic rd_phase = (state_ff == S_RD);

  // status levels and the end pulse
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_ff <= 1'b0;
      wr_ready_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != S_IDLE);
      wr_ready_ff <= (nxt_state == S_WR);
      done_ff <= (state_ff == S_DONE);
    end
  end

  // exception code stands until the next request is taken
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      exc_ff <= `EXC_NONE;
    end else if (take_req) begin
      exc_ff <= req_exc;
    end
  end

  // read word answer, one word per cycle of the read phase
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.valid <= rd_phase;
      rsp_ff.last <= rd_phase && (cnt_ff == 8'h01);
      rsp_ff.data <= rd_phase ? mem[rd_idx] : 16'h0000;
    end
  end

  // hand-off pulse, one cycle after the word is taken, from the edge that stores it
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conv_ff <= 1'b0;
    end else begin
      conv_ff <= take_wr && is_hand;
    end
  end

  // input image byte read
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      img_v_ff <= 1'b0;
      img_d_ff <= 8'h00;
    end else begin
      img_v_ff <= img_rd_i;
      img_d_ff <= img_rd_i ? ir_byte : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign busy_o = busy_ff;
  assign wr_ready_o = wr_ready_ff;
  assign rsp_o = rsp_ff;
  assign done_o = done_ff;
  assign exc_o = exc_ff;
  assign img_rd_valid_o = img_v_ff;
  assign img_rd_data_o = img_d_ff;
  assign convey_start_o = conv_ff;

endmodule : asm_access

// ---- sim/asm_access_asserts.sv ----
// concurrent checks on the request handler ports
`timescale 1ns/1ps
`include "asm_access_defines.svh"
module asm_access_asserts
  import asm_access_pkg::*;
#(
  parameter int NREG = 512,
  parameter int MAXQ = 45
) (
  input wire logic core_clk_i, // clock
  input wire logic rst_b_i, // reset
  input wire logic req_valid_i, // strobe
  input wire req_s req_i, // request
  input wire logic wr_valid_i, // word strobe
  input wire logic [15:0] wr_data_i, // word
  input wire logic wr_ready_o, // words taken
  input wire logic busy_o, // busy
  input wire rsp_s rsp_o, // read word
  input wire logic done_o, // end pulse
  input wire logic [7:0] exc_o, // exception
  input wire logic convey_start_o // hand-off
);
  // request accepted while idle
  wire take = req_valid_i & ~busy_o & ~done_o;
  wire fc_ok = req_i.fc inside {8'h03, 8'h06, 8'h10, 8'h17};
  wire in_asm = req_i.rd_off > `IN_ASM_OFF && req_i.rd_off < 16'h05f0;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_take_busy: assert property (take |=> busy_o)
    else $error("busy missing after take");
  chk_bad_func: assert property (take && !fc_ok |=> exc_o == 8'h01)
    else $error("bad function not flagged");
  chk_rd_qty: assert property (take && req_i.fc == 8'h03
    && req_i.rd_qty > MAXQ |=> exc_o == 8'h03) else $error("read qty");
  chk_wr_qty: assert property (take && req_i.fc == 8'h10
    && req_i.wr_qty > MAXQ |=> exc_o == 8'h03) else $error("write qty");
  chk_asm_start: assert property (take && req_i.fc == 8'h03 && in_asm
    && req_i.rd_qty inside {[1:MAXQ]} |=> exc_o == 8'h02)
    else $error("assembly start not refused");
  chk_exc_quiet: assert property (rsp_o.valid |-> exc_o == 8'h00)
    else $error("read word after exception");
  chk_err_done: assert property ($rose(busy_o) && exc_o != 8'h00
    |=> done_o) else $error("error answer late");
  chk_read_start: assert property ($rose(busy_o) && exc_o == 8'h00
    && $past(req_i.fc) == 8'h03 |=> rsp_o.valid) else $error("read late");
  chk_done_pulse: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  chk_hand_off: assert property (convey_start_o |-> $past(wr_valid_i
    && wr_ready_o && wr_data_i == 16'h0001)) else $error("hand-off pulse");
endmodule : asm_access_asserts
bind asm_access asm_access_asserts #(.NREG(NREG), .MAXQ(MAXQ)) u_chk (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i),
  .req_i(req_i), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i),
  .wr_ready_o(wr_ready_o), .busy_o(busy_o), .rsp_o(rsp_o),
  .done_o(done_o), .exc_o(exc_o), .convey_start_o(convey_start_o));

// ---- sim/client_feeder.sv ----
// remote client model feeding write words to the handler
`timescale 1ns/1ps
module client_feeder (
  input wire logic core_clk_i, // clock
  input wire logic rst_b_i, // reset
  input wire logic ready_i, // handler takes words
  input wire logic stall_i, // hold words back
  input wire logic [15:0] base_i, // first word value
  output logic valid_o, // word strobe
  output logic [15:0] data_o // word
);
  logic [15:0] cnt_ff;
  logic [15:0] last_ff;
  // word k is base plus k, held until taken; idle data never repeats
  assign valid_o = ready_i & ~stall_i;
  assign data_o = valid_o ? base_i + cnt_ff : ~last_ff;
  // index restarts once the handler stops asking
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_ff <= 16'h0000;
      last_ff <= 16'h0000;
    end else if (valid_o) begin
      cnt_ff <= cnt_ff + 16'h0001;
      last_ff <= data_o;
    end else if (!ready_i) begin
      cnt_ff <= 16'h0000;
    end
  end
endmodule : client_feeder

// ---- sim/asm_access_tb_top.sv ----
// self-checking bench for the holding register request handler
`timescale 1ns/1ps
`include "asm_access_defines.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module asm_access_tb_top;
  import asm_access_pkg::*;
  logic clk, rst_b, req_valid, wv, busy, wr_ready, done, conv, stall, slow;
  logic img_rd, img_wr, img_rd_valid, cv;
  logic [5:0] img_rd_addr, img_wr_addr;
  logic [7:0] img_wr_data, img_rd_data, exc;
  logic [15:0] wd, base;
  logic [15:0] words [0:63];
  req_s req;
  rsp_s rsp;
  int n_mismatch = 0, tests_run = 0, nw, nl;
  asm_access u_asm_access (.core_clk_i(clk), .rst_b_i(rst_b),
    .req_valid_i(req_valid), .req_i(req), .wr_valid_i(wv), .wr_data_i(wd),
    .img_rd_i(img_rd), .img_rd_addr_i(img_rd_addr), .img_wr_i(img_wr),
    .img_wr_addr_i(img_wr_addr), .img_wr_data_i(img_wr_data),
    .busy_o(busy), .wr_ready_o(wr_ready), .rsp_o(rsp), .done_o(done),
    .exc_o(exc), .img_rd_valid_o(img_rd_valid),
    .img_rd_data_o(img_rd_data), .convey_start_o(conv));
  client_feeder u_client_feeder (.core_clk_i(clk), .rst_b_i(rst_b),
    .ready_i(wr_ready), .stall_i(stall), .base_i(base), .valid_o(wv),
    .data_o(wd));
  // slow client holds back words every other cycle
  always @(posedge clk) stall <= slow & ~stall;
  // one request, collecting read words until done
  task automatic do_req(input logic [7:0] fc, input logic [15:0] ro,
      input logic [7:0] rq, input logic [15:0] wo, input logic [7:0] wq);
    int k;
    nw = 0;
    nl = 0;
    cv = 1'b0;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{fc, ro, rq, wo, wq};
    for (k = 0; k < 200; k++) begin
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
      if (conv === 1'b1) cv = 1'b1;
      if (rsp.valid === 1'b1) begin
        words[nw] = rsp.data;
        nw++;
        if (rsp.last === 1'b1) nl = nw;
      end
      if (done === 1'b1) break;
    end
    if (k == 200) `CHK(done, 1'b1)
    `CHK(nl, nw)
    `CHK(busy, 1'b0)
  endtask : do_req
  // refused request: code, no words
  task automatic err_req(input logic [7:0] fc, input logic [15:0] ro,
      input logic [7:0] rq, input logic [7:0] wq, input logic [7:0] e);
    do_req(fc, ro, rq, ro, wq);
    `CHK(exc, e)
    `CHK(nw, 0)
  endtask : err_req
  // image byte read, answer within two cycles
  task automatic img_read(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    img_rd <= 1'b1;
    img_rd_addr <= a;
    @(posedge clk);
    img_rd <= 1'b0;
    #1;
    `CHK(img_rd_valid, 1'b1)
    `CHK(img_rd_data, e)
  endtask : img_read
  task automatic img_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    img_wr <= 1'b1;
    img_wr_addr <= a;
    img_wr_data <= d;
    @(posedge clk);
    img_wr <= 1'b0;
  endtask : img_write
  task automatic t_wr_rd_max;
    base <= 16'h1000;
    slow <= 1'b1;
    do_req(8'h10, 16'h0000, 8'd0, 16'h0000, 8'd45);
    slow <= 1'b0;
    `CHK(exc, 8'h00)
    do_req(8'h03, 16'h0000, 8'd45, 16'h0000, 8'd0);
    `CHK(nw, 45)
    for (int k = 0; k < 45; k++) `CHK(words[k], 16'h1000 + k)
  endtask : t_wr_rd_max
  task automatic t_errors;
    base <= 16'hdead;
    err_req(8'h05, 16'h0000, 8'd1, 8'd0, 8'h01);
    err_req(8'h03, 16'h0000, 8'd46, 8'd0, 8'h03);
    err_req(8'h03, 16'h0000, 8'd0, 8'd0, 8'h03);
    err_req(8'h10, 16'h0000, 8'd0, 8'd46, 8'h03);
    err_req(8'h17, 16'h0000, 8'd1, 8'd46, 8'h03);
    err_req(8'h03, 16'h05df, 8'd1, 8'd0, 8'h02);
    err_req(8'h03, 16'h01ff, 8'd2, 8'd0, 8'h02);
    err_req(8'h03, 16'h05db, 8'd22, 8'd0, 8'h02);
    do_req(8'h03, 16'h0000, 8'd1, 16'h0000, 8'd0);
    `CHK(words[0], 16'h1000)
  endtask : t_errors
  task automatic t_hand_off;
    base <= 16'h0001;
    do_req(8'h06, 16'h0000, 8'd0, 16'd249, 8'd7);
    `CHK(cv, 1'b1)
    base <= 16'h0002;
    do_req(8'h06, 16'h0000, 8'd0, 16'd249, 8'd1);
    `CHK(cv, 1'b0)
    do_req(8'h03, 16'd249, 8'd1, 16'h0000, 8'd0);
    `CHK(words[0], 16'h0002)
  endtask : t_hand_off
  task automatic t_assembly;
    base <= 16'h0a5a;
    do_req(8'h06, 16'h0000, 8'd0, 16'd115, 8'd1);
    base <= 16'h5aa5;
    do_req(8'h06, 16'h0000, 8'd0, 16'd185, 8'd1);
    do_req(8'h03, `IN_ASM_OFF, 8'd5, 16'h0000, 8'd0);
    `CHK(words[0], 16'h0a5a)
    `CHK(words[4], 16'h5aa5)
    do_req(8'h03, `IN_ASM_OFF, 8'd21, 16'h0000, 8'd0);
    `CHK(nw, 21)
    img_read(6'd0, 8'h0a);
    img_read(6'd1, 8'h5a);
    img_read(6'd9, 8'ha5);
    img_read(6'd63, 8'h00);
  endtask : t_assembly
  task automatic t_images_rw;
    img_write(6'd0, 8'hab);
    img_write(6'd1, 8'hcd);
    do_req(8'h03, 16'd260, 8'd1, 16'h0000, 8'd0);
    `CHK(words[0], 16'habcd)
    base <= 16'h0300;
    do_req(8'h17, 16'd300, 8'd2, 16'd300, 8'd2);
    `CHK(words[0], 16'h0300)
    `CHK(words[1], 16'h0301)
  endtask : t_images_rw
  task end_of_test;
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {rst_b, req_valid, img_rd, img_wr, slow} = '0;
    req = '0;
    base = 16'h0000;
    {img_rd_addr, img_wr_addr, img_wr_data} = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_wr_rd_max();
    t_errors();
    t_hand_off();
    t_assembly();
    t_images_rw();
    end_of_test();
  end
endmodule : asm_access_tb_top
